/* hdl/fps_pkg.sv */
// constants, types and register map of the flash program data/address/status block
package fps_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [23:0] IDX_STATUS_HIGH = 24'h0e_0006;
  localparam logic [23:0] IDX_DATA_FIRST_LOW = 24'h0e_0008;
  localparam logic [23:0] IDX_DATA_FIRST_HIGH = 24'h0e_000a;
  localparam logic [23:0] IDX_DATA_SECOND_LOW = 24'h0e_000c;
  localparam logic [23:0] IDX_DATA_SECOND_HIGH = 24'h0e_000e;
  localparam logic [23:0] IDX_ADDR_LOW = 24'h0e_0010;
  localparam logic [23:0] IDX_ADDR_HIGH = 24'h0e_0012;
  localparam logic [23:0] IDX_CONTROL = 24'h0e_0020;
  localparam logic [23:0] IDX_ERROR = 24'h0e_0021;
  localparam logic [23:0] IDX_IRQ_STATUS = 24'h0e_0022;
  localparam logic [23:0] IDX_IRQ_MASK = 24'h0e_0023;

  localparam logic [23:0] BA_STATUS_HIGH = 24'(IDX_STATUS_HIGH * 4);
  localparam logic [23:0] BA_DATA_FIRST_LOW = 24'(IDX_DATA_FIRST_LOW * 4);
  localparam logic [23:0] BA_DATA_FIRST_HIGH = 24'(IDX_DATA_FIRST_HIGH * 4);
  localparam logic [23:0] BA_DATA_SECOND_LOW = 24'(IDX_DATA_SECOND_LOW * 4);
  localparam logic [23:0] BA_DATA_SECOND_HIGH = 24'(IDX_DATA_SECOND_HIGH * 4);
  localparam logic [23:0] BA_ADDR_LOW = 24'(IDX_ADDR_LOW * 4);
  localparam logic [23:0] BA_ADDR_HIGH = 24'(IDX_ADDR_HIGH * 4);
  localparam logic [23:0] BA_CONTROL = 24'(IDX_CONTROL * 4);
  localparam logic [23:0] BA_ERROR = 24'(IDX_ERROR * 4);
  localparam logic [23:0] BA_IRQ_STATUS = 24'(IDX_IRQ_STATUS * 4);
  localparam logic [23:0] BA_IRQ_MASK = 24'(IDX_IRQ_MASK * 4);

  // reset values and writable bits
  localparam logic [15:0] DATA_RST = 16'hffff;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_WMASK = 16'hffff;
  localparam logic [15:0] ADDR_LOW_WMASK = 16'hfffc;
  localparam logic [15:0] ADDR_HIGH_WMASK = 16'h001f;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // control register fields
  localparam int CTL_START_BIT = 15;
  localparam int CTL_SUSPEND_REQUEST_BIT = 14;
  localparam int CTL_WORD_BIT = 13;
  localparam int CTL_DWORD_BIT = 12;
  localparam int CTL_ERASE_BIT = 11;
  localparam int CTL_PROT_BIT = 8;
  localparam int CTL_MODSEL_BIT = 7;

  // status-high register fields
  localparam int STAT_BANK_LSB = 8;
  localparam int STAT_SECT_LSB = 0;

  // error and interrupt register fields
  localparam int ERR_FLAG_BIT = 0;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_SUSPEND_REQUEST_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    FPS_OP_WORD,
    FPS_OP_DWORD,
    FPS_OP_ERASE,
    FPS_OP_PROT
  } fps_op_t;

  typedef enum logic [1:0] {
    FPS_IDLE,
    FPS_RUN,
    FPS_SUSPEND_REQUEST
  } fps_state_t;

  // bank pair and sector pair of one module
  typedef struct packed {
    logic [1:0] bank;
    logic [1:0] sector;
  } fps_stat_t;

  // command handed to the flash engine
  typedef struct packed {
    fps_op_t op;
    logic module_sel;
    logic [20:2] addr;
    logic [63:0] data;
  } fps_cmd_t;

endpackage : fps_pkg

/* hdl/fps_reg16.sv */
// one 16-bit software register with byte lanes and a writable-bit mask
`timescale 1ns/1ps
`default_nettype none
module fps_reg16 #(
  parameter logic [15:0] RST = 16'h0000,
  parameter logic [15:0] WMASK = 16'hffff
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic we_in,
  input wire logic [1:0] be_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] q_out
);

  logic [15:0] q_r;
  logic [15:0] q_nxt;
  logic [15:0] lane;

  always_comb begin
    lane = {{8{be_in[1]}}, {8{be_in[0]}}} & WMASK;
    q_nxt = q_r;
    if (we_in) begin
      // reserved bits never take a write
      q_nxt = (q_r & ~lane) | (wdata_in & lane);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_r <= RST & WMASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule : fps_reg16
`default_nettype wire

/* hdl/fps_sticky.sv */
// sticky event bits, read-to-clear, masked onto one level interrupt
`timescale 1ns/1ps
`default_nettype none
module fps_sticky #(
  parameter int W = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] set_in,
  input wire logic clr_in,
  input wire logic [W-1:0] mask_in,
  output logic [W-1:0] q_out,
  output logic irq_out
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    // an event in the clearing cycle survives
    q_nxt = (clr_in ? '0 : q_r) | set_in;
    irq_nxt = |(q_nxt & mask_in);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_r <= '0;
      irq_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign q_out = q_r;
  assign irq_out = irq_r;

endmodule : fps_sticky
`default_nettype wire

/* hdl/fps_top.sv */
// flash program data, address and bank/sector status registers on avalon-mm
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fps_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [fps_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [fps_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [fps_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic cmd_start_out,
  output var fps_pkg::fps_cmd_t cmd_out,
  output logic suspend_out,
  input wire logic op_done_in,
  input wire logic op_error_in,
  input wire fps_pkg::fps_stat_t err_loc_in
);
  import fps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the access completes

  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic req;
  logic take;
  logic wr;
  logic [1:0] be;
  logic [15:0] wd;
  logic [15:0] rd16;
  logic hit;

  assign req = avs_read_in | avs_write_in;
  assign take = req & ~wait_r;
  assign wr = take & avs_write_in;
  assign be = avs_byteenable_in[1:0];
  assign wd = avs_writedata_in[15:0];

  logic [15:0] d0l;
  logic [15:0] d0h;
  logic [15:0] d1l;
  logic [15:0] d1h;
  logic [15:0] al;
  logic [15:0] ah;
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic err_r;
  logic err_nxt;
  fps_stat_t ext_r;
  fps_stat_t ext_nxt;
  fps_stat_t int_r;
  fps_stat_t int_nxt;
  fps_stat_t sel_stat;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_mask_nxt;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_stat;
  logic irq_clr;

  ////////////////////////////////////////////////////////////////////////////
  // data and address holding registers

  fps_reg16 #(.RST(DATA_RST), .WMASK(DATA_WMASK)) u_d0l (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .we_in(wr && avs_address_in == BA_DATA_FIRST_LOW),
    .be_in(be), .wdata_in(wd), .q_out(d0l)
  );
  fps_reg16 #(.RST(DATA_RST), .WMASK(DATA_WMASK)) u_d0h (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .we_in(wr && avs_address_in == BA_DATA_FIRST_HIGH),
    .be_in(be), .wdata_in(wd), .q_out(d0h)
  );
  fps_reg16 #(.RST(DATA_RST), .WMASK(DATA_WMASK)) u_d1l (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .we_in(wr && avs_address_in == BA_DATA_SECOND_LOW),
    .be_in(be), .wdata_in(wd), .q_out(d1l)
  );
  fps_reg16 #(.RST(DATA_RST), .WMASK(DATA_WMASK)) u_d1h (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .we_in(wr && avs_address_in == BA_DATA_SECOND_HIGH),
    .be_in(be), .wdata_in(wd), .q_out(d1h)
  );
  fps_reg16 #(.RST(ADDR_RST), .WMASK(ADDR_LOW_WMASK)) u_al (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .we_in(wr && avs_address_in == BA_ADDR_LOW),
    .be_in(be), .wdata_in(wd), .q_out(al)
  );
  fps_reg16 #(.RST(ADDR_RST), .WMASK(ADDR_HIGH_WMASK)) u_ah (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .we_in(wr && avs_address_in == BA_ADDR_HIGH),
    .be_in(be), .wdata_in(wd), .q_out(ah)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer

  fps_state_t state_r;
  fps_state_t state_nxt;
  logic start_r;
  logic start_nxt;
  fps_cmd_t cmd_r;
  fps_cmd_t cmd_nxt;
  logic suspend_request_r;
  logic suspend_request_nxt;
  logic ctl_wr;
  logic [3:0] op_bits;
  logic one_op;
  logic bad_align;
  logic setup_bad;
  fps_op_t op_sel;

  assign ctl_wr = wr && avs_address_in == BA_CONTROL && be == 2'b11;
  assign op_bits = {wd[CTL_WORD_BIT], wd[CTL_DWORD_BIT], wd[CTL_ERASE_BIT], wd[CTL_PROT_BIT]};
  assign one_op = op_bits == 4'b1000 || op_bits == 4'b0100 ||
                  op_bits == 4'b0010 || op_bits == 4'b0001;
  // a misaligned double word is refused rather than silently rounded
  assign bad_align = wd[CTL_DWORD_BIT] & al[2];

  // plain priority: any write data passes here, several op bits are refused later
  always_comb begin
    op_sel = FPS_OP_PROT;
    if (wd[CTL_WORD_BIT]) begin
      op_sel = FPS_OP_WORD;
    end else if (wd[CTL_DWORD_BIT]) begin
      op_sel = FPS_OP_DWORD;
    end else if (wd[CTL_ERASE_BIT]) begin
      op_sel = FPS_OP_ERASE;
    end
  end

  always_comb begin
    state_nxt = state_r;
    ctl_nxt = ctl_r;
    start_nxt = 1'b0;
    cmd_nxt = cmd_r;
    suspend_request_nxt = suspend_request_r;
    err_nxt = err_r;
    ext_nxt = ext_r;
    int_nxt = int_r;
    irq_set = '0;
    setup_bad = 1'b0;
    if (wr && avs_address_in == BA_ERROR && be[0] && !wd[ERR_FLAG_BIT]) begin
      err_nxt = 1'b0;
    end
    unique case (state_r)
      FPS_IDLE: begin
        if (ctl_wr) begin
          ctl_nxt = wd & ((16'h0001 << CTL_SUSPEND_REQUEST_BIT) | (16'h0001 << CTL_MODSEL_BIT) |
                          (16'h0001 << CTL_WORD_BIT) | (16'h0001 << CTL_DWORD_BIT) |
                          (16'h0001 << CTL_ERASE_BIT) | (16'h0001 << CTL_PROT_BIT));
          suspend_request_nxt = wd[CTL_SUSPEND_REQUEST_BIT];
          if (wd[CTL_START_BIT]) begin
            setup_bad = err_r | wd[CTL_SUSPEND_REQUEST_BIT] | ~one_op | bad_align;
            if (setup_bad) begin
              ctl_nxt = CTL_RST;
              suspend_request_nxt = 1'b0;
            end else begin
              ctl_nxt[CTL_START_BIT] = 1'b1;
              state_nxt = FPS_RUN;
              start_nxt = 1'b1;
              // operands are captured once so later writes cannot disturb them
              cmd_nxt.op = op_sel;
              cmd_nxt.module_sel = wd[CTL_MODSEL_BIT];
              cmd_nxt.addr = {ah[4:0], al[15:2]};
              cmd_nxt.data = {d1h, d1l, d0h, d0l};
              if (op_sel == FPS_OP_ERASE) begin
                if (wd[CTL_MODSEL_BIT]) begin
                  int_nxt = '{bank: 2'b11, sector: 2'b11};
                end else begin
                  ext_nxt = '{bank: 2'b11, sector: 2'b11};
                end
              end
            end
          end
        end
      end
      FPS_RUN: begin
        if (op_done_in) begin
          state_nxt = FPS_IDLE;
          ctl_nxt = CTL_RST;
          suspend_request_nxt = 1'b0;
          irq_set[IRQ_DONE_BIT] = 1'b1;
          if (op_error_in) begin
            err_nxt = 1'b1;
            irq_set[IRQ_ERR_BIT] = 1'b1;
            if (cmd_r.op == FPS_OP_ERASE) begin
              // what remains set marks where the erase failed
              if (cmd_r.module_sel) begin
                int_nxt = err_loc_in;
              end else begin
                ext_nxt = err_loc_in;
              end
            end
          end else begin
            ext_nxt = '0;
            int_nxt = '0;
          end
        end else if (ctl_wr && wd[CTL_SUSPEND_REQUEST_BIT]) begin
          // status bits are kept: they now mark the suspended bank and sectors
          state_nxt = FPS_SUSPEND_REQUEST;
          suspend_request_nxt = 1'b1;
          ctl_nxt[CTL_SUSPEND_REQUEST_BIT] = 1'b1;
          ctl_nxt[CTL_START_BIT] = 1'b0;
          irq_set[IRQ_SUSPEND_REQUEST_BIT] = 1'b1;
        end
      end
      FPS_SUSPEND_REQUEST: begin
        if (ctl_wr && wd[CTL_START_BIT] && !wd[CTL_SUSPEND_REQUEST_BIT]) begin
          state_nxt = FPS_RUN;
          suspend_request_nxt = 1'b0;
          start_nxt = 1'b1;
          ctl_nxt[CTL_SUSPEND_REQUEST_BIT] = 1'b0;
          ctl_nxt[CTL_START_BIT] = 1'b1;
        end
      end
      default: begin
        state_nxt = FPS_IDLE;
      end
    endcase
    if (setup_bad) begin
      err_nxt = 1'b1;
      irq_set[IRQ_ERR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= FPS_IDLE;
      ctl_r <= CTL_RST;
      start_r <= 1'b0;
      cmd_r <= '{op: FPS_OP_WORD, module_sel: 1'b0, addr: '0, data: '0};
      suspend_request_r <= 1'b0;
      err_r <= 1'b0;
      ext_r <= '0;
      int_r <= '0;
    end else begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      start_r <= start_nxt;
      cmd_r <= cmd_nxt;
      suspend_request_r <= suspend_request_nxt;
      err_r <= err_nxt;
      ext_r <= ext_nxt;
      int_r <= int_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  always_comb begin
    irq_mask_nxt = irq_mask_r;
    if (wr && avs_address_in == BA_IRQ_MASK && be[0]) begin
      irq_mask_nxt = wd[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign irq_clr = take & avs_read_in & (avs_address_in == BA_IRQ_STATUS);

  fps_sticky #(.W(IRQ_W)) u_irq (
    .clk_in(clk_in), .rstn_in(rstn_in), .set_in(irq_set), .clr_in(irq_clr),
    .mask_in(irq_mask_r), .q_out(irq_stat), .irq_out(irq_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux and handshake

  assign sel_stat = ctl_r[CTL_MODSEL_BIT] ? int_r : ext_r;

  always_comb begin
    hit = 1'b1;
    rd16 = 16'h0000;
    unique case (avs_address_in)
      BA_STATUS_HIGH: begin
        rd16 = 16'h0000;
        rd16[STAT_BANK_LSB +: 2] = sel_stat.bank;
        rd16[STAT_SECT_LSB +: 2] = sel_stat.sector;
      end
      BA_DATA_FIRST_LOW: rd16 = d0l;
      BA_DATA_FIRST_HIGH: rd16 = d0h;
      BA_DATA_SECOND_LOW: rd16 = d1l;
      BA_DATA_SECOND_HIGH: rd16 = d1h;
      BA_ADDR_LOW: rd16 = al;
      BA_ADDR_HIGH: rd16 = ah;
      BA_CONTROL: rd16 = ctl_r;
      BA_ERROR: rd16 = {15'h0000, err_r};
      BA_IRQ_STATUS: rd16 = {13'h0000, irq_stat};
      BA_IRQ_MASK: rd16 = {13'h0000, irq_mask_r};
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (req && wait_r) begin
      // data is latched a cycle early so the answer comes from a flop
      wait_nxt = 1'b0;
      rdata_nxt = hit ? {16'h0000, rd16} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out = rdata_r;
  assign cmd_start_out = start_r;
  assign cmd_out = cmd_r;
  assign suspend_out = suspend_request_r;

endmodule : fps_top
`default_nettype wire

/* tb/fps_top_checker.sv */
// assertions on the bus answer and command outputs of fps_top
`timescale 1ns/1ps
`default_nettype none
module fps_top_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [fps_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [fps_pkg::DATA_W-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out,
  input wire logic cmd_start_out,
  input wire fps_pkg::fps_cmd_t cmd_out,
  input wire logic suspend_out
);
  import fps_pkg::*;
  logic ack_w;
  logic rd_w;
  logic ctl_wr_w;
  assign ack_w = !avs_waitrequest_out;
  assign rd_w = ack_w && avs_read_in;
  assign ctl_wr_w = ack_w && avs_write_in && (avs_address_in == BA_CONTROL);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_ONE: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  AST_ACK_BOUND: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |-> ##[1:2] ack_w) else $error("no bus answer");
  AST_ACK_REQ: assert property (ack_w |-> avs_read_in || avs_write_in)
    else $error("answer without request");
  AST_UPPER_ZERO: assert property (rd_w |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_ADDRL_RSV: assert property (rd_w && avs_address_in == BA_ADDR_LOW
    |-> avs_readdata_out[1:0] == 2'h0) else $error("address low reserved bits set");
  AST_ADDRH_RSV: assert property (rd_w && avs_address_in == BA_ADDR_HIGH
    |-> avs_readdata_out[15:5] == 11'h000) else $error("address high reserved bits set");
  AST_STAT_RSV: assert property (rd_w && avs_address_in == BA_STATUS_HIGH
    |-> avs_readdata_out[15:10] == 6'h00 && avs_readdata_out[7:2] == 6'h00)
    else $error("status reserved bits set");
  AST_START_CAUSE: assert property (cmd_start_out |-> $past(ctl_wr_w))
    else $error("start without control write");
  AST_START_PULSE: assert property (cmd_start_out |=> !cmd_start_out)
    else $error("start longer than one cycle");
  AST_CMD_HOLD: assert property (!cmd_start_out |-> $stable(cmd_out))
    else $error("command changed without start");
  AST_DWORD_ALIGN: assert property (cmd_start_out && cmd_out.op == FPS_OP_DWORD
    |-> !cmd_out.addr[2]) else $error("odd double word started");
  // main scenarios reached
  COV_ERASE: cover property (cmd_start_out && cmd_out.op == FPS_OP_ERASE);
  COV_SUSPEND_REQUEST: cover property ($rose(suspend_out));
  COV_IRQ: cover property ($rose(irq_out));
endmodule : fps_top_checker
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the flash program data, address and status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fps_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [23:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [3:0] avs_byteenable_in = 4'h3;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic irq_out;
  logic cmd_start_out;
  fps_cmd_t cmd_out;
  logic suspend_out;
  logic op_done_in = 1'b0;
  logic op_error_in = 1'b0;
  fps_stat_t err_loc_in = '0;
  int mismatches = 0;
  int n_tests = 0;
  int starts = 0;
  logic [15:0] rd;

  fps_top fps_top_i (.clk_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .irq_out, .cmd_start_out, .cmd_out, .suspend_out, .op_done_in, .op_error_in,
    .err_loc_in);

  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (cmd_start_out === 1'b1) starts++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low; one idle edge before the next
  task automatic bus(input logic wr, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    rd = avs_readdata_out[15:0];
    if (n >= 100) check(1'b0, 1'b1);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [23:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    check(rd, exp);
  endtask : rc

  task automatic finish_op(input logic err, input logic [3:0] loc);
    op_done_in <= 1'b1;
    op_error_in <= err;
    err_loc_in <= loc;
    @(posedge clk_in);
    op_done_in <= 1'b0;
    op_error_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : finish_op

  // control write, then count start pulses seen
  task automatic start_cmd(input logic [15:0] ctl, input int exp);
    int s0;
    s0 = starts;
    wr(BA_CONTROL, ctl);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check(starts - s0, exp);
    @(posedge clk_in);
  endtask : start_cmd
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(BA_DATA_FIRST_LOW, 16'hffff);
    rc(BA_DATA_FIRST_HIGH, 16'hffff);
    rc(BA_DATA_SECOND_LOW, 16'hffff);
    rc(BA_DATA_SECOND_HIGH, 16'hffff);
    rc(BA_ADDR_LOW, 16'h0000);
    rc(BA_ADDR_HIGH, 16'h0000);
    rc(BA_STATUS_HIGH, 16'h0000);
  endtask : t_reset

  task automatic t_regs();
    wr(BA_ADDR_LOW, 16'hffff);
    rc(BA_ADDR_LOW, 16'hfffc);
    wr(BA_ADDR_HIGH, 16'hffff);
    rc(BA_ADDR_HIGH, 16'h001f);
    wr(24'h0f_0000, 16'h5a5a);
    rc(24'h0f_0000, 16'h0000);
    // one lane only: low byte moves, control write is ignored
    avs_byteenable_in <= 4'h1;
    wr(BA_DATA_FIRST_LOW, 16'h0000);
    start_cmd(16'ha000, 0);
    avs_byteenable_in <= 4'h3;
    rc(BA_DATA_FIRST_LOW, 16'hff00);
    rc(BA_ERROR, 16'h0000);
  endtask : t_regs

  task automatic t_word();
    wr(BA_IRQ_MASK, 16'h0007);
    wr(BA_DATA_FIRST_LOW, 16'h1234);
    wr(BA_DATA_FIRST_HIGH, 16'h5678);
    wr(BA_DATA_SECOND_LOW, 16'h9abc);
    wr(BA_DATA_SECOND_HIGH, 16'hdef0);
    wr(BA_ADDR_LOW, 16'h1238);
    wr(BA_ADDR_HIGH, 16'h0015);
    rc(BA_DATA_SECOND_LOW, 16'h9abc);
    start_cmd(16'ha000, 1);
    check(cmd_out.op, FPS_OP_WORD);
    check(cmd_out.addr, {5'h15, 14'h048e});
    check(cmd_out.data, 64'hdef0_9abc_5678_1234);
    finish_op(1'b0, 4'h0);
    check(irq_out, 1'b1);
    rc(BA_IRQ_STATUS, 16'h0001);
    rc(BA_IRQ_STATUS, 16'h0000);
    check(irq_out, 1'b0);
    rc(BA_CONTROL, 16'h0000);
  endtask : t_word

  task automatic t_erase_ext();
    start_cmd(16'h8800, 1);
    check(cmd_out.op, FPS_OP_ERASE);
    check(cmd_out.module_sel, 1'b0);
    rc(BA_STATUS_HIGH, 16'h0303);
    finish_op(1'b0, 4'hf);
    rc(BA_STATUS_HIGH, 16'h0000);
    rc(BA_IRQ_STATUS, 16'h0001);
  endtask : t_erase_ext

  task automatic t_suspend_request_int();
    start_cmd(16'h8880, 1);
    check(cmd_out.module_sel, 1'b1);
    rc(BA_STATUS_HIGH, 16'h0303);
    wr(BA_CONTROL, 16'h4880);
    check(suspend_out, 1'b1);
    rc(BA_STATUS_HIGH, 16'h0303);
    rc(BA_IRQ_STATUS, 16'h0004);
    start_cmd(16'h8880, 1);
    check(suspend_out, 1'b0);
    finish_op(1'b1, 4'h6);
    rc(BA_ERROR, 16'h0001);
    wr(BA_CONTROL, 16'h0080);
    rc(BA_STATUS_HIGH, 16'h0102);
    wr(BA_CONTROL, 16'h0000);
    rc(BA_STATUS_HIGH, 16'h0000);
    // a failed end is still an end: done and error both stick
    rc(BA_IRQ_STATUS, 16'h0003);
  endtask : t_suspend_request_int

  task automatic t_refuse();
    start_cmd(16'ha000, 0);
    wr(BA_ERROR, 16'h0000);
    rc(BA_ERROR, 16'h0000);
    start_cmd(16'hb000, 0);
    rc(BA_ERROR, 16'h0001);
    wr(BA_ERROR, 16'h0000);
    wr(BA_ADDR_LOW, 16'h0004);
    start_cmd(16'h9000, 0);
    rc(BA_ERROR, 16'h0001);
    wr(BA_ERROR, 16'h0000);
    wr(BA_ADDR_LOW, 16'h0008);
    start_cmd(16'h9000, 1);
    check(cmd_out.op, FPS_OP_DWORD);
    finish_op(1'b0, 4'h0);
    start_cmd(16'h8100, 1);
    check(cmd_out.op, FPS_OP_PROT);
    finish_op(1'b0, 4'h0);
    check(irq_out, 1'b1);
    wr(BA_IRQ_MASK, 16'h0000);
    // irq follows the mask one edge late
    @(negedge clk_in);
    check(irq_out, 1'b0);
    @(posedge clk_in);
    rc(BA_IRQ_STATUS, 16'h0003);
  endtask : t_refuse

  task automatic final_report();
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_regs();
    t_word();
    t_erase_ext();
    t_suspend_request_int();
    t_refuse();
    final_report();
  end

  // whole run is a few hundred cycles; this is about twenty times that
  initial begin
    #250000;
    mismatches++;
    final_report();
  end
endmodule : tb_top

bind fps_top fps_top_checker fps_top_checker_i (.clk_in, .rstn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out,
  .cmd_start_out, .cmd_out, .suspend_out);
`default_nettype wire
